//--- hw/fpcs_pkg.sv
// Purpose: constants for the flash programming host sequencer
// Assumes: one clock at 20 MHz
// Notes: command codes, timings and cycle counts

package fpcs_pkg;
    localparam int unsigned CLK_MHZ = 20;                 // clock rate
    localparam logic [7:0] CMD_ERASE = 8'h30;             // erase set-up and confirm
    localparam logic [7:0] CMD_PROG = 8'h40;              // program set-up
    localparam logic [7:0] CMD_RESET = 8'hFF;             // reset, written twice
    localparam int unsigned T_WE_LOW_NS = 60;             // strobe low width
    localparam int unsigned T_WE_HIGH_NS = 100;           // strobe high width
    localparam int unsigned T_OE_ACC_NS = 150;            // poll access time
    localparam int unsigned T_DIS_NS = 35;                // output disable time
    localparam int unsigned WE_LOW_CYC = (T_WE_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned WE_HIGH_CYC = (T_WE_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned OE_ACC_CYC = (T_OE_ACC_NS * CLK_MHZ + 999) / 1000 + 2;
    localparam int unsigned DIS_CYC = (T_DIS_NS * CLK_MHZ + 999) / 1000;
    localparam logic [7:0] CNT_RST = 8'h00;               // counter reset value
    localparam int unsigned POLL_BIT = 7;                 // poll_status_bit position
    localparam int unsigned TOGGLE_BIT = 6;               // toggle_status_bit position
    localparam logic [1:0] OP_ERASE = 2'h0;               // chip erase request
    localparam logic [1:0] OP_PROG = 2'h1;                // byte program request
    localparam logic [1:0] OP_RESET = 2'h2;               // double reset request
    localparam logic [1:0] OP_READ = 2'h3;                // array read request
    typedef enum logic [3:0] {
        FPCS_IDLE = 4'h0,
        FPCS_WLOW = 4'h1,
        FPCS_WHIGH = 4'h2,
        FPCS_RLOW = 4'h3,
        FPCS_RDIS = 4'h4,
        FPCS_DONE = 4'h5
    } fpcs_state_t;
endpackage : fpcs_pkg

//--- hw/fpcs_host.sv
// Purpose: host controller that drives flash program/erase pin sequences
// Assumes: device pins synchronous enough to drive from a 20 MHz clock
// Notes: data pins are three signals; oe high while host drives
`timescale 1ns/1ns
`default_nettype none

module fpcs_host
    import fpcs_pkg::*;
#(
    parameter int unsigned ADDR_W = 16,   // address width
    parameter int unsigned POLL_MAX = 65535 // polls before failure
) (
    input wire logic clk,                  // 20 MHz clock
    input wire logic rst,                  // async reset, high
    input wire logic req_valid,            // request strobe, one cycle
    input wire logic [1:0] req_op,         // operation code
    input wire logic [ADDR_W-1:0] req_addr, // target address
    input wire logic [7:0] req_data,       // byte to store
    output logic req_busy,                 // sequence in progress
    output logic done_pulse,               // one-cycle completion
    output logic done_fail,                // poll limit exceeded
    output logic [7:0] rd_data,            // read or final status byte
    output logic vpp_high,                 // programming supply enable
    output logic ce_n,                     // chip select, low active
    output logic oe_n,                     // output enable, low active
    output logic we_n,                     // write strobe, low active
    output logic [ADDR_W-1:0] addr_out,    // address pins
    output logic [7:0] data_bus_out,       // data pins out
    output logic data_bus_oe,              // high while host drives data
    input wire logic [7:0] data_bus_in     // data pins in
);
    fpcs_state_t state_reg, state_next;    // sequencer state
    logic [7:0] cnt_reg;                   // timing counter
    logic [1:0] op_reg;                    // latched operation
    logic [1:0] wr_idx_reg;                // write number in sequence
    logic [7:0] wdata_reg;                 // stored byte, true value
    logic [15:0] polls_reg;                // poll count
    logic [7:0] prev_reg;                  // previous poll byte
    logic have_prev_reg;                   // previous poll valid
    logic [7:0] sync1_reg, sync2_reg;      // data input synchroniser
    logic [7:0] wr_byte;                   // byte for current write
    logic [1:0] op_cur;                    // operation the next strobe belongs to
    logic [1:0] idx_cur;                   // write number the next strobe carries
    logic [7:0] data_cur;                  // true byte the next strobe stores
    logic last_write;                      // current write is last of sequence
    logic is_poll;                         // operation needs polling
    logic toggle_still;                    // toggle bit stable
    logic poll_ok;                         // completion condition met
    logic poll_fail;                       // poll budget spent

    // a strobe launched from idle sees the request being taken, and one
    // launched from strobe-high sees the write number after its step
    assign op_cur = (state_reg == FPCS_IDLE) ? req_op : op_reg;
    assign data_cur = (state_reg == FPCS_IDLE) ? req_data : wdata_reg;
    assign idx_cur = (state_reg == FPCS_IDLE) ? 2'd0 :
                     (state_reg == FPCS_WHIGH) ? wr_idx_reg + 2'd1 : wr_idx_reg;
    // byte driven on each write of the sequence
    assign wr_byte = (op_cur == OP_ERASE) ? CMD_ERASE :
                     (op_cur == OP_RESET) ? CMD_RESET :
                     (idx_cur == 2'd0) ? CMD_PROG : ~data_cur;
    assign last_write = (op_reg == OP_READ) || (wr_idx_reg == 2'd1);
    assign is_poll = (op_reg == OP_ERASE) || (op_reg == OP_PROG);
    // latest poll byte against the one before it
    assign toggle_still = have_prev_reg &&
        (prev_reg[TOGGLE_BIT] == rd_data[TOGGLE_BIT]);
    // erase done on bit 7 high; program done on true bits 7 and 6
    assign poll_ok = toggle_still && ((op_reg == OP_ERASE) ? rd_data[POLL_BIT] :
        (rd_data[POLL_BIT:TOGGLE_BIT] == wdata_reg[POLL_BIT:TOGGLE_BIT]));
    assign poll_fail = (polls_reg == POLL_MAX[15:0]);

    // next-state decode
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FPCS_IDLE: begin
                if (req_valid) begin
                    state_next = (req_op == OP_READ) ? FPCS_RLOW : FPCS_WLOW;
                end
            end
            FPCS_WLOW: begin
                if (cnt_reg == 8'd0) begin
                    state_next = FPCS_WHIGH;
                end
            end
            FPCS_WHIGH: begin
                if (cnt_reg == 8'd0) begin
                    // polls begin only after the second strobe rises
                    state_next = last_write ? (is_poll ? FPCS_RLOW : FPCS_DONE)
                                            : FPCS_WLOW;
                end
            end
            FPCS_RLOW: begin
                if (cnt_reg == 8'd0) begin
                    state_next = FPCS_RDIS;
                end
            end
            FPCS_RDIS: begin
                if (cnt_reg == 8'd0) begin
                    if (!is_poll || poll_ok || poll_fail) begin
                        state_next = FPCS_DONE;
                    end else begin
                        state_next = FPCS_RLOW;
                    end
                end
            end
            FPCS_DONE: state_next = FPCS_IDLE;
            default: state_next = FPCS_IDLE;
        endcase
    end

    // input synchroniser for the data pins
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_reg <= CNT_RST;
            sync2_reg <= CNT_RST;
        end else begin
            sync1_reg <= data_bus_in;
            sync2_reg <= sync1_reg;
        end
    end

    // state and timing counter
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= FPCS_IDLE;
            cnt_reg <= CNT_RST;
        end else begin
            state_reg <= state_next;
            if (state_next != state_reg) begin
                case (state_next)
                    FPCS_WLOW: cnt_reg <= 8'(WE_LOW_CYC - 1);
                    FPCS_WHIGH: cnt_reg <= 8'(WE_HIGH_CYC - 1);
                    FPCS_RLOW: cnt_reg <= 8'(OE_ACC_CYC - 1);
                    FPCS_RDIS: cnt_reg <= 8'(DIS_CYC);
                    default: cnt_reg <= CNT_RST;
                endcase
            end else if (state_reg == FPCS_RDIS && state_next == FPCS_RLOW) begin
                cnt_reg <= 8'(OE_ACC_CYC - 1);
            end else if (cnt_reg != 8'd0) begin
                cnt_reg <= cnt_reg - 8'd1;
            end
        end
    end

    // request latch, write index and poll history
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            op_reg <= OP_READ;
            wr_idx_reg <= 2'd0;
            wdata_reg <= CNT_RST;
            polls_reg <= 16'd0;
            prev_reg <= CNT_RST;
            have_prev_reg <= 1'b0;
            rd_data <= CNT_RST;
            done_fail <= 1'b0;
        end else begin
            if (state_reg == FPCS_IDLE && req_valid) begin
                op_reg <= req_op;
                wdata_reg <= req_data;
                wr_idx_reg <= 2'd0;
                polls_reg <= 16'd0;
                have_prev_reg <= 1'b0;
                done_fail <= 1'b0;
            end
            if (state_reg == FPCS_WHIGH && cnt_reg == 8'd0) begin
                wr_idx_reg <= wr_idx_reg + 2'd1;
            end
            // sample at end of access, just before output enable rises
            if (state_reg == FPCS_RLOW && cnt_reg == 8'd0) begin
                prev_reg <= rd_data;
                rd_data <= sync2_reg;
            end
            if (state_reg == FPCS_RDIS && cnt_reg == 8'd0) begin
                have_prev_reg <= 1'b1;
                polls_reg <= polls_reg + 16'd1;
                // failure leaves device needing the double reset op
                done_fail <= is_poll && !poll_ok && poll_fail;
            end
        end
    end

    // pin drivers, all registered
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vpp_high <= 1'b0;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
            addr_out <= '0;
            data_bus_out <= CNT_RST;
            data_bus_oe <= 1'b0;
            req_busy <= 1'b0;
            done_pulse <= 1'b0;
        end else begin
            // supply raised with the first request and held high until reset so commands are accepted
            vpp_high <= (state_next != FPCS_IDLE) || vpp_high;
            // chip select drops with the first strobe, or with output enable on a read, and rises only on entering done, so only the falling edges coincide
            ce_n <= (state_next == FPCS_IDLE) || (state_next == FPCS_DONE);
            we_n <= (state_next != FPCS_WLOW);
            oe_n <= (state_next != FPCS_RLOW);
            // data kept driven one cycle past the strobe rise for hold time
            data_bus_oe <= (state_next == FPCS_WLOW) || (state_reg == FPCS_WLOW);
            data_bus_out <= (state_next == FPCS_WLOW) ? wr_byte : data_bus_out;
            if (state_reg == FPCS_IDLE && req_valid) begin
                addr_out <= req_addr;
            end
            req_busy <= (state_next != FPCS_IDLE) && (state_next != FPCS_DONE);
            done_pulse <= (state_next == FPCS_DONE);
        end
    end
endmodule : fpcs_host

`default_nettype wire

//--- testbench/fpcs_host_properties.sv
// Purpose: port checks for the host sequencer
// Assumes: bound into fpcs_host
// Notes: one clock domain
`timescale 1ns/1ns
`default_nettype none
module fpcs_host_properties
    import fpcs_pkg::*;
#(parameter int unsigned ADDR_W = 16) (
    input wire logic clk, // clock
    input wire logic rst, // reset
    input wire logic req_valid, // request
    input wire logic [1:0] req_op, // op code
    input wire logic req_busy, // busy
    input wire logic done_pulse, // done
    input wire logic vpp_high, // supply
    input wire logic ce_n, // select
    input wire logic oe_n, // output enable
    input wire logic we_n, // strobe
    input wire logic [ADDR_W-1:0] addr_out, // address
    input wire logic [7:0] data_bus_out, // data out
    input wire logic data_bus_oe // drive enable
);
    // first byte each write sequence must carry
    wire logic [7:0] first_cmd = (req_op == OP_ERASE) ? CMD_ERASE :
        (req_op == OP_PROG) ? CMD_PROG : CMD_RESET;
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    a_write_cycle: assert property (!we_n |-> !ce_n && oe_n && data_bus_oe)
        else $error("bad write");
    a_read_release: assert property (!oe_n |-> we_n && !ce_n && !data_bus_oe)
        else $error("bad read");
    a_standby_tri: assert property (ce_n |-> !data_bus_oe) else $error("bus driven");
    a_supply_first: assert property (!ce_n |-> vpp_high) else $error("no supply");
    a_strobe_width: assert property ($fell(we_n) |=> !we_n ##1 we_n ##1 we_n)
        else $error("strobe width");
    a_pins_hold: assert property (!we_n && $past(!we_n) |-> $stable(addr_out)
        && $stable(data_bus_out)) else $error("pins moved");
    a_first_cmd: assert property (req_valid && !req_busy && !done_pulse && req_op != OP_READ
        |=> !we_n && data_bus_out == $past(first_cmd)) else $error("first command");
    a_done_single: assert property (done_pulse |=> !done_pulse) else $error("long done");
    c_done: cover property (done_pulse);
    c_poll: cover property ($fell(oe_n));
    c_write: cover property ($fell(we_n));
endmodule : fpcs_host_properties
bind fpcs_host fpcs_host_properties #(.ADDR_W(ADDR_W)) fpcs_host_properties_inst (
    .clk(clk), .rst(rst), .req_valid(req_valid), .req_op(req_op), .req_busy(req_busy),
    .done_pulse(done_pulse), .vpp_high(vpp_high), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr_out(addr_out), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe));
`default_nettype wire

//--- testbench/fpcs_dev_model.sv
// Purpose: flash device model on the pins
// Assumes: busy for a set number of reads
// Notes: released bus shows inverse of last byte
`timescale 1ns/1ns
`default_nettype none
module fpcs_dev_model #(parameter int BUSY_READS = 3) (
    input wire logic ce_n, // select
    input wire logic oe_n, // output enable
    input wire logic we_n, // strobe
    input wire logic vpp_high, // supply
    input wire logic [15:0] addr, // address
    input wire logic [7:0] din, // bus level
    input wire logic hang, // never finish
    output logic [7:0] dq // device side
);
    logic [7:0] mem [16]; // small array
    logic [7:0] cmd_reg = 8'h00, val = 8'h00; // command, last byte
    logic [3:0] wa = 4'h0; // latched address
    logic tog = 1'b0, ers = 1'b0; // toggle, erase running
    int left = 0; // busy reads left
    wire logic go_prog = cmd_reg == 8'h40;
    wire logic go_ers = cmd_reg == 8'h30 && din == 8'h30;
    wire logic go_rst = cmd_reg == 8'hFF && din == 8'hFF;
    initial foreach (mem[i]) mem[i] = 8'h00;
    always @(negedge vpp_high) cmd_reg = 8'h00;
    // short settle after each strobe edge so select falling alongside is seen
    always @(negedge we_n) #1 if (!ce_n) wa = addr[3:0];
    // data and commands on the rising strobe
    always @(posedge we_n) #1 if (!ce_n && vpp_high) begin
        if (go_prog) mem[wa] = ~din;
        if (go_ers) foreach (mem[i]) mem[i] = 8'hFF;
        ers = go_ers;
        left = (go_prog || go_ers) ? BUSY_READS : 0;
        cmd_reg = (go_prog || go_ers || go_rst) ? 8'h00 : din;
    end
    // status while busy, array data once done
    always @(negedge oe_n) #1 if (!ce_n) begin
        tog = ~tog;
        val = (left > 0) ? {ers ? 1'b0 : ~mem[addr[3:0]][7], tog, 6'h00}
            : mem[addr[3:0]];
        if (left > 0 && !hang) left--;
    end
    assign dq = (!ce_n && !oe_n) ? val : ~val;
endmodule : fpcs_dev_model
`default_nettype wire

//--- testbench/fpcs_host_tb.sv
// Purpose: self-checking bench for the host sequencer
// Assumes: device model on the pins
// Notes: short poll limit reaches the failure path
`timescale 1ns/1ns
`default_nettype none
module fpcs_host_tb
    import fpcs_pkg::*;
;
    logic clk = 1'b0, rst = 1'b1, req_valid = 1'b0, hang = 1'b0; // drives
    logic [1:0] req_op = OP_READ; // op code
    logic [15:0] req_addr = 16'h0000, addr_out; // addresses
    logic [7:0] req_data = 8'h00, rd_data, data_bus_out, dev_q, fl_rd; // bytes
    logic req_busy, done_pulse, done_fail, vpp_high, ce_n, oe_n, we_n, data_bus_oe, fl;
    int n_errors = 0, tests_run = 0, cyc = 0; // counters
    wire logic [7:0] data_bus_in = data_bus_oe ? data_bus_out : dev_q;
    fpcs_host #(.ADDR_W(16), .POLL_MAX(8)) fpcs_host_inst (.clk(clk), .rst(rst),
        .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_data(req_data),
        .req_busy(req_busy), .done_pulse(done_pulse), .done_fail(done_fail),
        .rd_data(rd_data), .vpp_high(vpp_high), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .addr_out(addr_out), .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
        .data_bus_in(data_bus_in));
    fpcs_dev_model #(.BUSY_READS(3)) fpcs_dev_model_inst (.ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .vpp_high(vpp_high), .addr(addr_out), .din(data_bus_in),
        .hang(hang), .dq(dev_q));
    initial forever #25 clk = ~clk;
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : final_report
    // cycle ceiling against hangs
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            final_report();
        end
    end
    task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_val
    // one request, wait for done, keep flag and byte
    task automatic run_op(input logic [1:0] op, input logic [15:0] ad, input logic [7:0] dt);
        @(negedge clk);
        req_op = op;
        req_addr = ad;
        req_data = dt;
        req_valid = 1'b1;
        @(negedge clk);
        req_valid = 1'b0;
        check_val({7'h00, req_busy}, 8'h01);
        // a hang is caught by the cycle ceiling
        while (done_pulse !== 1'b1) @(negedge clk);
        check_val({7'h00, req_busy}, 8'h00);
        fl = done_fail;
        fl_rd = rd_data;
    endtask : run_op
    // program then read back at once
    task automatic t_program();
        run_op(OP_PROG, 16'h0003, 8'hA5);
        check_val({7'h00, fl}, 8'h00);
        check_val(fl_rd, 8'hA5);
        check_val(fpcs_dev_model_inst.mem[3], 8'hA5);
        run_op(OP_READ, 16'h0003, 8'h00);
        check_val(fl_rd, 8'hA5);
    endtask : t_program
    // chip erase leaves the array erased
    task automatic t_erase();
        run_op(OP_ERASE, 16'h0000, 8'h00);
        check_val({7'h00, fl}, 8'h00);
        check_val(fpcs_dev_model_inst.mem[3], 8'hFF);
    endtask : t_erase
    // stuck program fails, double reset recovers
    task automatic t_fail();
        hang = 1'b1;
        run_op(OP_PROG, 16'h0007, 8'h3C);
        check_val({7'h00, fl}, 8'h01);
        hang = 1'b0;
        run_op(OP_RESET, 16'h0000, 8'h00);
        check_val({7'h00, fl}, 8'h00);
        check_val(fpcs_dev_model_inst.cmd_reg, 8'h00);
        run_op(OP_PROG, 16'h0007, 8'h5A);
        check_val({7'h00, fl}, 8'h00);
        check_val(fpcs_dev_model_inst.mem[7], 8'h5A);
    endtask : t_fail
    initial begin
        repeat (3) @(negedge clk);
        rst = 1'b0;
        check_val({7'h00, vpp_high}, 8'h00);
        t_program();
        t_erase();
        t_fail();
        final_report();
    end
endmodule : fpcs_host_tb
`default_nettype wire
